// [logic/tsc_pkg.sv]
// Constants and types shared by the sensor configuration and lock logic
package tsc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  typedef logic [7:0] tsc_addr_t;
  typedef logic [15:0] tsc_word_t;

  localparam tsc_addr_t TSC_ADDR_CFG = 8'h01;
  localparam tsc_addr_t TSC_ADDR_UPPER = 8'h02;
  localparam tsc_addr_t TSC_ADDR_LOWER = 8'h03;
  localparam tsc_addr_t TSC_ADDR_CRIT = 8'h04;
  localparam tsc_addr_t TSC_ADDR_TEMP = 8'h05;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int TSC_CFG_HYST_LO = 9;
  localparam int TSC_CFG_HYST_HI = 10;
  localparam int TSC_CFG_SHDN = 8;
  localparam int TSC_CFG_CLOCK = 7;
  localparam int TSC_CFG_WLOCK = 6;
  localparam int TSC_CFG_CLR = 5;
  localparam int TSC_CFG_ESTAT = 4;
  localparam int TSC_CFG_MODE = 0;

  // ----------------------------------------------------------------
  // Temperature register status bits
  // ----------------------------------------------------------------
  localparam int TSC_TEMP_CRIT = 15;
  localparam int TSC_TEMP_ABOVE = 14;
  localparam int TSC_TEMP_BELOW = 13;

  // ----------------------------------------------------------------
  // Hysteresis codes and amounts, LSB = 0.0625 degC
  // ----------------------------------------------------------------
  typedef logic [1:0] tsc_hyst_t;
  typedef logic [13:0] tsc_hamt_t;

  localparam tsc_hyst_t TSC_HYST_OFF = 2'h0;
  localparam tsc_hyst_t TSC_HYST_1P5 = 2'h1;
  localparam tsc_hyst_t TSC_HYST_3P0 = 2'h2;
  localparam tsc_hyst_t TSC_HYST_6P0 = 2'h3;
  localparam tsc_hamt_t TSC_HAMT_0 = 14'h0000;
  localparam tsc_hamt_t TSC_HAMT_1P5 = 14'h0018;
  localparam tsc_hamt_t TSC_HAMT_3P0 = 14'h0030;
  localparam tsc_hamt_t TSC_HAMT_6P0 = 14'h0060;

  localparam tsc_word_t TSC_WORD_ZERO = 16'h0000;

endpackage : tsc_pkg

// [logic/tsc_trip_eval.sv]
// One trip status flag with hysteresis around its threshold
`timescale 1ns/1ps
`default_nettype none

module tsc_trip_eval #(
  parameter int W = 14,
  parameter bit IS_UPPER = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sample_valid,
  input wire logic signed [W-1:0] sample,
  input wire logic signed [W-1:0] threshold,
  input wire logic signed [W-1:0] hyst,
  output logic flag_ff
);

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  logic signed [W-1:0] release_pt;
  logic set_cond;
  logic clr_cond;

  // Hysteresis delays the release of an upper trip and the setting of a lower trip
  assign release_pt = threshold - hyst;
  assign set_cond = IS_UPPER ? (sample > threshold) : (sample < release_pt);
  assign clr_cond = IS_UPPER ? (sample <= release_pt) : (sample >= threshold);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else if (sample_valid) begin
      if (set_cond) begin
        flag_ff <= 1'b1;
      end else if (clr_cond) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  upper_trip_a: assert property (IS_UPPER && sample_valid && sample > threshold |=> flag_ff)
    else $error("upper flag not set above threshold");
  upper_hold_a: assert property (IS_UPPER && flag_ff && sample_valid && sample > release_pt
    |=> flag_ff)
    else $error("upper flag released inside hysteresis band");
  lower_clear_a: assert property (!IS_UPPER && sample_valid && sample >= threshold |=> !flag_ff)
    else $error("lower flag not cleared at or above threshold");

endmodule : tsc_trip_eval

`default_nettype wire

// [logic/tsc_config_lock.sv]
// Configuration, lock and event logic of the thermal sensor
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Two-bit field selects hysteresis: off, 1.5, 3 or 6 degrees; resets off.
// - Selected hysteresis applies around every trip threshold for status flags.
// - Above-window flag sets when temperature exceeds the upper boundary.
// - Above-window flag holds until temperature drops to upper minus hysteresis.
// - Below-window flag clears when temperature is at or above lower boundary.
// - Event output follows the same hysteresis as the status flags.
// - Shutdown bit: 0 sensor enabled (reset), 1 sensor disabled.
// - While shut down, no conversion and no temperature events.
// - Setting shutdown ignored while any lock is set; clearing always allowed.
// - Critical lock set refuses changes to the critical trip register.
// - Critical lock sticks at 1 until power-on reset.
// - One ordinary write sets a lock bit.
// - Window lock set refuses changes to upper and lower boundaries.
// - Window lock resets to 0 and sticks at 1 until power-on reset.
// - Writing 1 to clear bit drops a latched event in interrupt mode.
// - In comparator mode the clear bit is ignored.
module tsc_config_lock
  import tsc_pkg::*;
#(
  parameter int TEMP_W = 13
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire tsc_pkg::tsc_addr_t reg_addr,
  input wire tsc_pkg::tsc_word_t reg_wdata,
  output tsc_pkg::tsc_word_t reg_rdata_ff,
  input wire logic sample_valid,
  input wire logic [TEMP_W-1:0] sample_temp,
  output logic sensor_enable_ff,
  output logic event_out_ff,
  output logic above_window_ff,
  output logic below_window_ff,
  output logic crit_trip_ff
);
  import tsc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Status bits occupy the top three bits; widest hysteresis must fit the signed compare
  if (TEMP_W < 7 || TEMP_W > TSC_TEMP_BELOW) begin : g_bad_width
    $error("TEMP_W out of range");
  end

  localparam int EW = TEMP_W + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic tsc_hamt_t hyst_amount(input tsc_hyst_t sel);
    case (sel)
      TSC_HYST_OFF: hyst_amount = TSC_HAMT_0;
      TSC_HYST_1P5: hyst_amount = TSC_HAMT_1P5;
      TSC_HYST_3P0: hyst_amount = TSC_HAMT_3P0;
      TSC_HYST_6P0: hyst_amount = TSC_HAMT_6P0;
      default: hyst_amount = TSC_HAMT_0;
    endcase
  endfunction : hyst_amount

  function automatic logic signed [EW-1:0] sext(input logic [TEMP_W-1:0] v);
    sext = {v[TEMP_W-1], v};
  endfunction : sext

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic cfg_wr;
  logic upper_wr;
  logic lower_wr;
  logic crit_wr;
  logic any_lock;
  logic sample_upd;

  tsc_hyst_t hyst_sel_ff;
  logic shutdown_ff;
  logic crit_lock_ff;
  logic window_lock_ff;
  logic event_mode_ff;
  logic [TEMP_W-1:0] upper_ff;
  logic [TEMP_W-1:0] lower_ff;
  logic [TEMP_W-1:0] crit_ff;
  logic [TEMP_W-1:0] temp_ff;
  logic alert_latch_ff;
  logic prev_any_ff;
  logic any_flag;
  logic flag_rise;
  logic clr_evt;
  logic nxt_alert_latch;

  assign cfg_wr = reg_wr_en && (reg_addr == TSC_ADDR_CFG);
  assign upper_wr = reg_wr_en && (reg_addr == TSC_ADDR_UPPER);
  assign lower_wr = reg_wr_en && (reg_addr == TSC_ADDR_LOWER);
  assign crit_wr = reg_wr_en && (reg_addr == TSC_ADDR_CRIT);
  assign any_lock = crit_lock_ff || window_lock_ff;
  assign sample_upd = sample_valid && !shutdown_ff;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hyst_sel_ff <= TSC_HYST_OFF;
    end else if (cfg_wr) begin
      hyst_sel_ff <= reg_wdata[TSC_CFG_HYST_HI:TSC_CFG_HYST_LO];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shutdown_ff <= 1'b0;
    end else if (cfg_wr) begin
      if (!reg_wdata[TSC_CFG_SHDN]) begin
        shutdown_ff <= 1'b0;
      end else if (!any_lock) begin
        shutdown_ff <= 1'b1;
      end
    end
  end

  // Locks only ever set; nrst stands in for the internal power-on reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      crit_lock_ff <= 1'b0;
      window_lock_ff <= 1'b0;
    end else if (cfg_wr) begin
      if (reg_wdata[TSC_CFG_CLOCK]) begin
        crit_lock_ff <= 1'b1;
      end
      if (reg_wdata[TSC_CFG_WLOCK]) begin
        window_lock_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      event_mode_ff <= 1'b0;
    end else if (cfg_wr && !any_lock) begin
      event_mode_ff <= reg_wdata[TSC_CFG_MODE];
    end
  end

  // ----------------------------------------------------------------
  // Trip registers
  // ----------------------------------------------------------------
  // Locked writes vanish without any bus error
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      upper_ff <= '0;
      lower_ff <= '0;
    end else begin
      if (upper_wr && !window_lock_ff) begin
        upper_ff <= reg_wdata[TEMP_W-1:0];
      end
      if (lower_wr && !window_lock_ff) begin
        lower_ff <= reg_wdata[TEMP_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      crit_ff <= '0;
    end else if (crit_wr && !crit_lock_ff) begin
      crit_ff <= reg_wdata[TEMP_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      temp_ff <= '0;
    end else if (sample_upd) begin
      temp_ff <= sample_temp;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sensor_enable_ff <= 1'b0;
    end else begin
      sensor_enable_ff <= !shutdown_ff;
    end
  end

  // ----------------------------------------------------------------
  // Trip flags
  // ----------------------------------------------------------------
  logic signed [EW-1:0] hyst_ext;

  assign hyst_ext = EW'(hyst_amount(hyst_sel_ff));

  tsc_trip_eval #(.W(EW), .IS_UPPER(1'b1)) u_above (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sample_valid(sample_upd),
    .sample(sext(sample_temp)),
    .threshold(sext(upper_ff)),
    .hyst(hyst_ext),
    .flag_ff(above_window_ff)
  );

  tsc_trip_eval #(.W(EW), .IS_UPPER(1'b0)) u_below (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sample_valid(sample_upd),
    .sample(sext(sample_temp)),
    .threshold(sext(lower_ff)),
    .hyst(hyst_ext),
    .flag_ff(below_window_ff)
  );

  tsc_trip_eval #(.W(EW), .IS_UPPER(1'b1)) u_crit (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sample_valid(sample_upd),
    .sample(sext(sample_temp)),
    .threshold(sext(crit_ff)),
    .hyst(hyst_ext),
    .flag_ff(crit_trip_ff)
  );

  // ----------------------------------------------------------------
  // Event output
  // ----------------------------------------------------------------
  // Latch arms on a new trip only, so a cleared event stays clear while held
  assign any_flag = above_window_ff || below_window_ff || crit_trip_ff;
  assign flag_rise = any_flag && !prev_any_ff && !shutdown_ff;
  assign clr_evt = cfg_wr && reg_wdata[TSC_CFG_CLR] && event_mode_ff;
  assign nxt_alert_latch = (flag_rise && event_mode_ff) || (alert_latch_ff && !clr_evt);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prev_any_ff <= 1'b0;
      alert_latch_ff <= 1'b0;
    end else begin
      prev_any_ff <= any_flag;
      alert_latch_ff <= nxt_alert_latch;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      event_out_ff <= 1'b0;
    end else begin
      event_out_ff <= !shutdown_ff && (event_mode_ff ? alert_latch_ff : any_flag);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  tsc_word_t rd_word;

  always_comb begin
    rd_word = TSC_WORD_ZERO;
    case (reg_addr)
      TSC_ADDR_CFG: begin
        rd_word[TSC_CFG_HYST_HI:TSC_CFG_HYST_LO] = hyst_sel_ff;
        rd_word[TSC_CFG_SHDN] = shutdown_ff;
        rd_word[TSC_CFG_CLOCK] = crit_lock_ff;
        rd_word[TSC_CFG_WLOCK] = window_lock_ff;
        rd_word[TSC_CFG_ESTAT] = event_out_ff;
        rd_word[TSC_CFG_MODE] = event_mode_ff;
      end
      TSC_ADDR_UPPER: rd_word[TEMP_W-1:0] = upper_ff;
      TSC_ADDR_LOWER: rd_word[TEMP_W-1:0] = lower_ff;
      TSC_ADDR_CRIT: rd_word[TEMP_W-1:0] = crit_ff;
      TSC_ADDR_TEMP: begin
        rd_word[TEMP_W-1:0] = temp_ff;
        rd_word[TSC_TEMP_CRIT] = crit_trip_ff;
        rd_word[TSC_TEMP_ABOVE] = above_window_ff;
        rd_word[TSC_TEMP_BELOW] = below_window_ff;
      end
      default: rd_word = TSC_WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= TSC_WORD_ZERO;
    end else if (reg_rd_en) begin
      reg_rdata_ff <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  crit_lock_sticky_a: assert property ($rose(crit_lock_ff) |=> crit_lock_ff [*8])
    else $error("critical lock dropped");
  window_lock_sticky_a: assert property (window_lock_ff |=> window_lock_ff)
    else $error("window lock dropped");
  lock_single_write_a: assert property (cfg_wr && reg_wdata[TSC_CFG_CLOCK] |=> crit_lock_ff)
    else $error("single write did not set lock");
  crit_locked_a: assert property (crit_wr && crit_lock_ff |=> $stable(crit_ff))
    else $error("locked critical register changed");
  window_locked_a: assert property ((upper_wr || lower_wr) && window_lock_ff
    |=> $stable(upper_ff) && $stable(lower_ff))
    else $error("locked window register changed");
  shdn_refused_a: assert property (cfg_wr && reg_wdata[TSC_CFG_SHDN] && any_lock
    && !shutdown_ff |=> !shutdown_ff)
    else $error("shutdown set while locked");
  shdn_clear_a: assert property (cfg_wr && !reg_wdata[TSC_CFG_SHDN]
    |=> !shutdown_ff ##1 sensor_enable_ff)
    else $error("shutdown clear refused");
  shdn_quiet_a: assert property (shutdown_ff |=> !event_out_ff)
    else $error("event while shut down");
  comparator_event_a: assert property (!event_mode_ff
    |=> event_out_ff == $past(!shutdown_ff && any_flag))
    else $error("comparator event mismatch");
  // A clear that keeps interrupt mode and meets no new trip drops the latch, then the pin
  intr_clear_a: assert property (clr_evt && !(flag_rise && event_mode_ff)
    && reg_wdata[TSC_CFG_MODE] |=> !alert_latch_ff ##1 !event_out_ff)
    else $error("event clear ignored in interrupt mode");
  hyst_code_a: assert property (hyst_sel_ff == TSC_HYST_6P0 |-> hyst_ext == EW'(TSC_HAMT_6P0))
    else $error("hysteresis amount wrong");

  lock_set_c: cover property (cfg_wr && reg_wdata[TSC_CFG_WLOCK] ##1 upper_wr);
  intr_cycle_c: cover property (flag_rise && event_mode_ff ##[1:20] clr_evt);
  hyst_hold_c: cover property (above_window_ff && hyst_sel_ff != TSC_HYST_OFF ##1
    above_window_ff && sample_upd);
  shdn_c: cover property (cfg_wr && reg_wdata[TSC_CFG_SHDN] ##1 shutdown_ff);

endmodule : tsc_config_lock

`default_nettype wire

// [tb/tsc_host_model.sv]
// Host model that reaches the sensor registers over the register port
`timescale 1ns/1ps
`default_nettype none

module tsc_host_model (
  input wire logic clk_sys,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output tsc_pkg::tsc_addr_t reg_addr,
  output tsc_pkg::tsc_word_t reg_wdata,
  input wire tsc_pkg::tsc_word_t reg_rdata_ff
);
  import tsc_pkg::*;

  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'hFE;
    reg_wdata = 16'hFFFF;
  end

  // Released lines show the inverse so a stale value cannot pass
  task automatic wr(input tsc_addr_t a, input tsc_word_t d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    // Room for the event path, which lags a write by two cycles
    repeat (3) @(posedge clk_sys);
  endtask : wr

  task automatic rd(input tsc_addr_t a, output tsc_word_t d);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata_ff;
  endtask : rd
endmodule : tsc_host_model

`default_nettype wire

// [tb/thermal_sensor_config_lock_logic_test.sv]
// Self-checking bench of the sensor configuration and lock logic
`timescale 1ns/1ps
`default_nettype none

module thermal_sensor_config_lock_logic_test;
  import tsc_pkg::*;

  localparam logic [12:0] UP = 13'h01C0;
  localparam logic [12:0] LO = 13'h0100;
  localparam logic [12:0] MID = 13'h0150;
  localparam logic [12:0] CRIT = 13'h0FFF;

  logic clk_sys;
  logic nrst;
  logic reg_wr_en;
  logic reg_rd_en;
  tsc_addr_t reg_addr;
  tsc_word_t reg_wdata;
  tsc_word_t reg_rdata_ff;
  logic sample_valid;
  logic [12:0] sample_temp;
  logic sensor_enable_ff;
  logic event_out_ff;
  logic above_window_ff;
  logic below_window_ff;
  logic crit_trip_ff;
  int miscompares;
  int n_checks;
  tsc_word_t rv;

  tsc_config_lock #(.TEMP_W(13)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .sample_valid(sample_valid), .sample_temp(sample_temp),
    .sensor_enable_ff(sensor_enable_ff), .event_out_ff(event_out_ff),
    .above_window_ff(above_window_ff), .below_window_ff(below_window_ff),
    .crit_trip_ff(crit_trip_ff)
  );

  tsc_host_model i_host (
    .clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input tsc_word_t exp, input tsc_word_t got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rdchk(input string what, input tsc_addr_t a, input tsc_word_t exp);
    i_host.rd(a, rv);
    chk(what, exp, rv);
  endtask : rdchk

  // Comparator mode only, critical threshold out of reach: event is the OR of the window flags
  task automatic flags(input logic ea, input logic eb);
    chk("above", {15'h0000, ea}, {15'h0000, above_window_ff});
    chk("below", {15'h0000, eb}, {15'h0000, below_window_ff});
    chk("crit", 16'h0000, {15'h0000, crit_trip_ff});
    chk("event", {15'h0000, ea | eb}, {15'h0000, event_out_ff});
  endtask : flags

  task automatic smp(input logic [12:0] t);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample_temp <= t;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    sample_temp <= ~t;
    repeat (3) @(posedge clk_sys);
  endtask : smp

  task automatic ev(input logic e);
    chk("event", {15'h0000, e}, {15'h0000, event_out_ff});
  endtask : ev

  task automatic en(input logic e);
    chk("enable", {15'h0000, e}, {15'h0000, sensor_enable_ff});
  endtask : en

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdchk("cfg", TSC_ADDR_CFG, 16'h0000);
    rdchk("upper", TSC_ADDR_UPPER, 16'h0000);
    en(1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_hyst;
    logic [12:0] amt [4];
    amt = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
    i_host.wr(TSC_ADDR_CRIT, {3'h0, CRIT});
    i_host.wr(TSC_ADDR_UPPER, {3'h0, UP});
    i_host.wr(TSC_ADDR_LOWER, {3'h0, LO});
    for (int h = 0; h < 4; h++) begin
      i_host.wr(TSC_ADDR_CFG, 16'(h) << 9);
      rdchk("cfg", TSC_ADDR_CFG, 16'(h) << 9);
      smp(MID);
      flags(1'b0, 1'b0);
      smp(UP + 13'h0001);
      flags(1'b1, 1'b0);
      smp(UP - amt[h] + 13'h0001);
      flags(1'b1, 1'b0);
      smp(UP - amt[h]);
      flags(1'b0, 1'b0);
      smp(LO - amt[h] - 13'h0001);
      flags(1'b0, 1'b1);
      smp(LO - 13'h0001);
      flags(1'b0, 1'b1);
      smp(LO);
      flags(1'b0, 1'b0);
    end
    $display("test hysteresis done");
  endtask : t_hyst

  task automatic t_shdn;
    smp(UP + 13'h0001);
    rdchk("temp", TSC_ADDR_TEMP, {3'b010, UP + 13'h0001});
    i_host.wr(TSC_ADDR_CFG, 16'h0100);
    en(1'b0);
    ev(1'b0);
    smp(MID);
    chk("above", 16'h0001, {15'h0000, above_window_ff});
    rdchk("temp", TSC_ADDR_TEMP, {3'b010, UP + 13'h0001});
    rdchk("cfg", TSC_ADDR_CFG, 16'h0100);
    i_host.wr(TSC_ADDR_CFG, 16'h0000);
    en(1'b1);
    smp(MID);
    flags(1'b0, 1'b0);
    $display("test shutdown done");
  endtask : t_shdn

  task automatic t_intr;
    i_host.wr(TSC_ADDR_CFG, 16'h0001);
    smp(UP + 13'h0001);
    ev(1'b1);
    smp(MID);
    ev(1'b1);
    i_host.wr(TSC_ADDR_CFG, 16'h0001);
    ev(1'b1);
    i_host.wr(TSC_ADDR_CFG, 16'h0021);
    ev(1'b0);
    rdchk("cfg", TSC_ADDR_CFG, 16'h0001);
    i_host.wr(TSC_ADDR_CFG, 16'h0000);
    smp(UP + 13'h0001);
    i_host.wr(TSC_ADDR_CFG, 16'h0020);
    ev(1'b1);
    smp(MID);
    flags(1'b0, 1'b0);
    $display("test interrupt done");
  endtask : t_intr

  task automatic t_locks;
    i_host.wr(TSC_ADDR_CFG, 16'h0100);
    i_host.wr(TSC_ADDR_CFG, 16'h0140);
    rdchk("cfg", TSC_ADDR_CFG, 16'h0140);
    i_host.wr(TSC_ADDR_CFG, 16'h0040);
    rdchk("cfg", TSC_ADDR_CFG, 16'h0040);
    i_host.wr(TSC_ADDR_CFG, 16'h0140);
    rdchk("cfg", TSC_ADDR_CFG, 16'h0040);
    en(1'b1);
    i_host.wr(TSC_ADDR_UPPER, 16'h00AA);
    rdchk("upper", TSC_ADDR_UPPER, {3'h0, UP});
    i_host.wr(TSC_ADDR_LOWER, 16'h00AA);
    rdchk("lower", TSC_ADDR_LOWER, {3'h0, LO});
    i_host.wr(TSC_ADDR_CRIT, 16'h0AAA);
    rdchk("crit", TSC_ADDR_CRIT, 16'h0AAA);
    i_host.wr(TSC_ADDR_CFG, 16'h0080);
    i_host.wr(TSC_ADDR_CFG, 16'h0000);
    rdchk("cfg", TSC_ADDR_CFG, 16'h00C0);
    i_host.wr(TSC_ADDR_CRIT, 16'h0FFF);
    rdchk("crit", TSC_ADDR_CRIT, 16'h0AAA);
    // Trips only if the refused write really left the old threshold
    smp(13'h0AAB);
    chk("crit", 16'h0001, {15'h0000, crit_trip_ff});
    ev(1'b1);
    rdchk("temp", TSC_ADDR_TEMP, 16'hCAAB);
    $display("test locks done");
  endtask : t_locks

  // Only power-on reset may drop the locks
  task automatic t_por;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    i_host.wr(TSC_ADDR_UPPER, 16'h00AA);
    rdchk("upper", TSC_ADDR_UPPER, 16'h00AA);
    $display("test power-on reset done");
  endtask : t_por

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    miscompares = 0;
    n_checks = 0;
    nrst = 1'b0;
    sample_valid = 1'b0;
    sample_temp = 13'h1FFF;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_hyst();
    t_shdn();
    t_intr();
    t_locks();
    t_por();
    stop_test();
  end

  // Whole run is under 400 cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule : thermal_sensor_config_lock_logic_test

`default_nettype wire
